/* File: common/rsc_consts.svh */
// constants for the rolling shutter scan controller and sensor scan model
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

`define RSC_CLK_PERIOD_NS   50
`define RSC_PULSE_NS        200
`define RSC_PULSE_CYC       ((`RSC_PULSE_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_LINE_TIME_US    135

`define RSC_ARRAY_COLS      11'h506
`define RSC_ARRAY_ROWS      11'h406
`define RSC_SUB_COLS        11'h140
`define RSC_SUB_ROWS        11'h100
`define RSC_SUB_STEP        11'h004

`define RSC_OFS_CMD         8'h00
`define RSC_OFS_LEVEL       8'h04
`define RSC_OFS_STATUS      8'h08

`define RSC_CMD_R_SYNC      0
`define RSC_CMD_R_STEP      1
`define RSC_CMD_C_SYNC      2
`define RSC_CMD_C_STEP      3
`define RSC_CMD_L_SYNC      4
`define RSC_CMD_L_STEP      5

`define RSC_LVL_SELECT      0
`define RSC_LVL_RESET       1
`define RSC_LVL_LEFT        2
`define RSC_LVL_HOLD        3
`define RSC_LVL_CAL         4
`define RSC_LVL_SUB         5
`define RSC_LEVEL_RESET     6'h00

`define RSC_ST_BUSY         0
`define RSC_ST_END_LSB      1
`define RSC_ST_LIVE_LSB     4

`endif

/* File: common/rsc_pkg.sv */
// types shared by the scan controller and the sensor scan model
package rsc_pkg;
    typedef enum logic [1:0] {
        PULSE_IDLE,
        PULSE_DRIVE,
        PULSE_RECOVER
    } rsc_pulse_state_type;

    typedef logic [10:0] rsc_pos_type;
    typedef logic [2:0]  rsc_axis_type;
endpackage

/* File: common/rsc_scan_if.sv */
// scan pins between the timing controller and the sensor
`timescale 1ns/1ps
interface rsc_scan_if;
    logic right_row_sync_n;
    logic right_row_step_clock;
    logic right_row_end_n;
    logic column_sync_n;
    logic column_step_clock;
    logic column_end_n;
    logic left_row_sync_n;
    logic left_row_step_clock;
    logic left_row_end_n;
    logic column_track_hold;
    logic column_amp_calibrate;
    logic row_select;
    logic row_reset;
    logic pointer_left_sel;
    logic viewfinder_subsample;

    modport controller (
        output right_row_sync_n,
        output right_row_step_clock,
        input  right_row_end_n,
        output column_sync_n,
        output column_step_clock,
        input  column_end_n,
        output left_row_sync_n,
        output left_row_step_clock,
        input  left_row_end_n,
        output column_track_hold,
        output column_amp_calibrate,
        output row_select,
        output row_reset,
        output pointer_left_sel,
        output viewfinder_subsample
    );

    modport sensor (
        input  right_row_sync_n,
        input  right_row_step_clock,
        output right_row_end_n,
        input  column_sync_n,
        input  column_step_clock,
        output column_end_n,
        input  left_row_sync_n,
        input  left_row_step_clock,
        output left_row_end_n,
        input  column_track_hold,
        input  column_amp_calibrate,
        input  row_select,
        input  row_reset,
        input  pointer_left_sel,
        input  viewfinder_subsample
    );
endinterface

/* File: rtl/rsc_sensor_scan.sv */
// sensor end: row and column scan pointers driven from the scan pins
//
// Operation
// - right row sync low returns pointer first
// - right row pointer steps on falling clock
// - right row end low after last row
// - column sync low returns pointer first
// - column pointer steps on falling clock
// - column end low after last column
// - left row sync low returns pointer first
// - left row pointer steps on falling clock
// - left row end low after last row
// - track/hold high holds, low tracks
// - calibrate pulse high calibrates column amplifiers
// - select high selects addressed row
// - reset high resets addressed row
// - pointer side high left, low right
// - viewfinder high gives 1:4, 320x256 scan
// - exposure steps are whole 135 us lines
// - integration equals delay between row pointers
// - column pattern applied before each row
// - array spans 1286 columns by 1030 rows
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_sensor_scan (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    rsc_scan_if.sensor                scan,
    output logic [10:0]               right_row,
    output logic [10:0]               left_row,
    output logic [10:0]               column,
    output logic [10:0]               addressed_row,
    output logic                      addressed_left,
    output logic                      row_selected,
    output logic                      row_resetting,
    output logic                      column_holding,
    output logic                      column_calibrating,
    output logic                      subsample_mode
);
    // axis index: 0 right row, 1 column, 2 left row
    localparam int AXES = 3;

    // pin order: sync and clock per axis, then the level pins
    localparam int NPINS = 12;

    logic [NPINS-1:0]            pin_raw;
    logic [NPINS-1:0]            pin_meta_q;
    logic [NPINS-1:0]            pin_q;
    rsc_pkg::rsc_axis_type       sync_n_s;
    rsc_pkg::rsc_axis_type       step_s;
    rsc_pkg::rsc_axis_type       step_prev_q;
    rsc_pkg::rsc_axis_type       fall;
    rsc_pkg::rsc_axis_type       past_q;
    rsc_pkg::rsc_axis_type       end_q;
    rsc_pkg::rsc_pos_type        pos_q [AXES];
    logic                        sub_s;
    logic                        left_s;
    logic                        select_s;
    logic                        reset_s;
    logic                        hold_s;
    logic                        cal_s;
    logic [10:0]                 right_row_q;
    logic [10:0]                 left_row_q;
    logic [10:0]                 column_q;
    logic [10:0]                 addressed_row_q;
    logic                        addressed_left_q;
    logic                        row_selected_q;
    logic                        row_resetting_q;
    logic                        column_holding_q;
    logic                        column_calibrating_q;
    logic                        subsample_mode_q;

    // last position of an axis; in viewfinder mode only every fourth one is visited
    function automatic rsc_pkg::rsc_pos_type last_pos(input int axis, input logic sub);
        rsc_pkg::rsc_pos_type n;
        n = (axis == 1) ? (sub ? `RSC_SUB_COLS : `RSC_ARRAY_COLS)
                        : (sub ? `RSC_SUB_ROWS : `RSC_ARRAY_ROWS);
        if (sub) begin
            last_pos = 11'((n - 11'h001) * `RSC_SUB_STEP);
        end else begin
            last_pos = n - 11'h001;
        end
    endfunction

    function automatic rsc_pkg::rsc_pos_type next_pos(input rsc_pkg::rsc_pos_type p,
                                                     input logic sub);
        next_pos = sub ? 11'(p + `RSC_SUB_STEP) : 11'(p + 11'h001);
    endfunction

    assign pin_raw = {scan.viewfinder_subsample,
                      scan.pointer_left_sel,
                      scan.row_reset,
                      scan.row_select,
                      scan.column_amp_calibrate,
                      scan.column_track_hold,
                      scan.left_row_step_clock,
                      scan.left_row_sync_n,
                      scan.column_step_clock,
                      scan.column_sync_n,
                      scan.right_row_step_clock,
                      scan.right_row_sync_n};

    // pins come from another chip, so every one passes two flip-flops first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_q <= 12'h015;
            pin_q      <= 12'h015;
        end else begin
            pin_meta_q <= pin_raw;
            pin_q      <= pin_meta_q;
        end
    end

    assign sync_n_s = {pin_q[4], pin_q[2], pin_q[0]};
    assign step_s   = {pin_q[5], pin_q[3], pin_q[1]};
    assign hold_s   = pin_q[6];
    assign cal_s    = pin_q[7];
    assign select_s = pin_q[8];
    assign reset_s  = pin_q[9];
    assign left_s   = pin_q[10];
    assign sub_s    = pin_q[11];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_prev_q <= 3'h0;
        end else begin
            step_prev_q <= step_s;
        end
    end

    // pointers shift on the falling edge of their step clock
    assign fall = step_prev_q & ~step_s;

    // sync is a level: while it is low the pointer is held at its first position
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < AXES; i++) begin
                pos_q[i] <= 11'h000;
            end
            past_q <= 3'h0;
            end_q  <= 3'h0;
        end else begin
            for (int i = 0; i < AXES; i++) begin
                if (!sync_n_s[i]) begin
                    pos_q[i]  <= 11'h000;
                    past_q[i] <= 1'b0;
                    end_q[i]  <= 1'b0;
                end else if (fall[i]) begin
                    if (past_q[i]) begin
                        // end flag covers only the first pulse after the last position
                        end_q[i] <= 1'b0;
                    end else if (pos_q[i] >= last_pos(i, sub_s)) begin
                        past_q[i] <= 1'b1;
                        end_q[i]  <= 1'b1;
                    end else begin
                        pos_q[i] <= next_pos(pos_q[i], sub_s);
                    end
                end
            end
        end
    end

    assign scan.right_row_end_n = ~end_q[0];
    assign scan.column_end_n    = ~end_q[1];
    assign scan.left_row_end_n  = ~end_q[2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            right_row_q <= 11'h000;
            left_row_q  <= 11'h000;
            column_q    <= 11'h000;
        end else begin
            right_row_q <= pos_q[0];
            column_q    <= pos_q[1];
            left_row_q  <= pos_q[2];
        end
    end

    // row select and reset act through the pointer chosen by the side pin;
    // a pointer that ran off the array addresses no row
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addressed_row_q  <= 11'h000;
            addressed_left_q <= 1'b0;
            row_selected_q   <= 1'b0;
            row_resetting_q  <= 1'b0;
        end else begin
            addressed_left_q <= left_s;
            addressed_row_q  <= left_s ? pos_q[2] : pos_q[0];
            row_selected_q   <= select_s & ~(left_s ? past_q[2] : past_q[0]);
            row_resetting_q  <= reset_s & ~(left_s ? past_q[2] : past_q[0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            column_holding_q     <= 1'b0;
            column_calibrating_q <= 1'b0;
            subsample_mode_q     <= 1'b0;
        end else begin
            column_holding_q     <= hold_s;
            column_calibrating_q <= cal_s;
            subsample_mode_q     <= sub_s;
        end
    end

    assign right_row          = right_row_q;
    assign left_row           = left_row_q;
    assign column             = column_q;
    assign addressed_row      = addressed_row_q;
    assign addressed_left     = addressed_left_q;
    assign row_selected       = row_selected_q;
    assign row_resetting      = row_resetting_q;
    assign column_holding     = column_holding_q;
    assign column_calibrating = column_calibrating_q;
    assign subsample_mode     = subsample_mode_q;
endmodule

/* File: rtl/rsc_scan_ctrl.sv */
// controller end: AHB-Lite register slave that drives the scan pins
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_scan_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    rsc_scan_if.controller   scan
);
    localparam int PULSE = `RSC_PULSE_CYC;

    rsc_pkg::rsc_pulse_state_type state_q;
    logic [7:0]                   cnt_q;
    logic [5:0]                   cmd_q;
    logic [5:0]                   level_q;
    logic [2:0]                   sync_n_q;
    logic [2:0]                   step_q;
    logic [2:0]                   end_meta_q;
    logic [2:0]                   end_live_q;
    logic [2:0]                   end_sticky_q;
    logic                         wr_pend_q;
    logic [7:0]                   wr_addr_q;
    logic [31:0]                  hrdata_q;
    logic                         addr_ok;
    logic                         cmd_wr;
    logic [31:0]                  status;

    assign addr_ok = hsel & hready & htrans[1];
    assign cmd_wr  = wr_pend_q & (wr_addr_q == `RSC_OFS_CMD) & (state_q == rsc_pkg::PULSE_IDLE)
                     & (hwdata[5:0] != 6'h00);
    assign status  = {25'h0000000, end_live_q, end_sticky_q, state_q != rsc_pkg::PULSE_IDLE};

    // zero wait state slave, always OKAY; hsize is not checked, only words are used
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_ok & ~hwrite) begin
                unique case (haddr[7:0])
                    `RSC_OFS_LEVEL:  hrdata_q <= {26'h0000000, level_q};
                    `RSC_OFS_STATUS: hrdata_q <= status;
                    default:         hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= `RSC_LEVEL_RESET;
        end else if (wr_pend_q & (wr_addr_q == `RSC_OFS_LEVEL)) begin
            level_q <= hwdata[5:0];
        end
    end

    // a command asserts its pins for PULSE cycles then idles them for PULSE cycles,
    // long enough for the sensor's two-stage input sampling; busy commands are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= rsc_pkg::PULSE_IDLE;
            cnt_q    <= 8'h00;
            cmd_q    <= 6'h00;
            sync_n_q <= 3'h7;
            step_q   <= 3'h0;
        end else begin
            unique case (state_q)
                rsc_pkg::PULSE_IDLE: begin
                    if (cmd_wr) begin
                        cmd_q    <= hwdata[5:0];
                        state_q  <= rsc_pkg::PULSE_DRIVE;
                        cnt_q    <= 8'(PULSE - 1);
                        sync_n_q <= ~{hwdata[`RSC_CMD_L_SYNC], hwdata[`RSC_CMD_C_SYNC],
                                      hwdata[`RSC_CMD_R_SYNC]};
                        // separate step bits let software set the row delay between pointers
                        step_q   <= {hwdata[`RSC_CMD_L_STEP], hwdata[`RSC_CMD_C_STEP],
                                     hwdata[`RSC_CMD_R_STEP]};
                    end
                end
                rsc_pkg::PULSE_DRIVE: begin
                    if (cnt_q == 8'h00) begin
                        state_q  <= rsc_pkg::PULSE_RECOVER;
                        cnt_q    <= 8'(PULSE - 1);
                        sync_n_q <= 3'h7;
                        step_q   <= 3'h0;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                rsc_pkg::PULSE_RECOVER: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= rsc_pkg::PULSE_IDLE;
                        cmd_q   <= 6'h00;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // end flags are sticky; a new end in the clearing cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            end_meta_q   <= 3'h0;
            end_live_q   <= 3'h0;
            end_sticky_q <= 3'h0;
        end else begin
            end_meta_q <= ~{scan.left_row_end_n, scan.column_end_n, scan.right_row_end_n};
            end_live_q <= end_meta_q;
            if (wr_pend_q & (wr_addr_q == `RSC_OFS_STATUS)) begin
                end_sticky_q <= (end_sticky_q & ~hwdata[3:1]) | end_live_q;
            end else begin
                end_sticky_q <= end_sticky_q | end_live_q;
            end
        end
    end

    assign scan.right_row_sync_n     = sync_n_q[0];
    assign scan.column_sync_n        = sync_n_q[1];
    assign scan.left_row_sync_n      = sync_n_q[2];
    assign scan.right_row_step_clock = step_q[0];
    assign scan.column_step_clock    = step_q[1];
    assign scan.left_row_step_clock  = step_q[2];
    assign scan.row_select           = level_q[`RSC_LVL_SELECT];
    assign scan.row_reset            = level_q[`RSC_LVL_RESET];
    assign scan.pointer_left_sel     = level_q[`RSC_LVL_LEFT];
    assign scan.column_track_hold    = level_q[`RSC_LVL_HOLD];
    assign scan.column_amp_calibrate = level_q[`RSC_LVL_CAL];
    assign scan.viewfinder_subsample = level_q[`RSC_LVL_SUB];
    assign hreadyout                 = 1'b1;
    assign hresp                     = 1'b0;
    assign hrdata                    = hrdata_q;
endmodule

/* File: dv/rsc_scan_sva.sv */
// concurrent checks on the scan pins joining the controller and the sensor
`timescale 1ns/1ps
module rsc_scan_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic right_row_sync_n,
    input wire logic right_row_step_clock,
    input wire logic right_row_end_n,
    input wire logic column_sync_n,
    input wire logic column_step_clock,
    input wire logic column_end_n,
    input wire logic left_row_sync_n,
    input wire logic left_row_step_clock,
    input wire logic left_row_end_n
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // pulses must stay wide enough for the sensor's two-flop input stage
    chk_sync_pulse_width: assert property ($fell(right_row_sync_n) |->
        !right_row_sync_n [*4] ##1 right_row_sync_n) else $error("sync pulse width wrong");
    chk_step_pulse_width: assert property ($rose(column_step_clock) |->
        column_step_clock [*4] ##1 !column_step_clock) else $error("step pulse width wrong");
    chk_rsync_clears_end: assert property ($fell(right_row_sync_n) |->
        ##[1:8] right_row_end_n) else $error("right sync left end flag low");
    chk_csync_clears_end: assert property ($fell(column_sync_n) |->
        ##[1:8] column_end_n) else $error("column sync left end flag low");
    chk_lsync_clears_end: assert property ($fell(left_row_sync_n) |->
        ##[1:8] left_row_end_n) else $error("left sync left end flag low");
    // an end flag may only appear after a falling step, never inside a pulse
    chk_rend_after_fall: assert property ($fell(right_row_end_n) |->
        !right_row_step_clock && right_row_sync_n) else $error("right end flag mistimed");
    chk_cend_after_fall: assert property ($fell(column_end_n) |->
        !column_step_clock && column_sync_n) else $error("column end flag mistimed");
    chk_lend_after_fall: assert property ($fell(left_row_end_n) |->
        !left_row_step_clock && left_row_sync_n) else $error("left end flag mistimed");

    cover property ($fell(right_row_end_n));
    cover property ($fell(column_end_n));
    cover property ($fell(left_row_end_n));
endmodule

/* File: dv/tb_top.sv */
// self-checking bench: AHB-Lite master, pointer model and both scan ends
`timescale 1ns/1ps
`include "rsc_consts.svh"
module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [10:0] right_row, left_row, column, addressed_row;
    logic        addressed_left, row_selected, row_resetting;
    logic        column_holding, column_calibrating, subsample_mode;
    int          err_count;
    int          check_count;
    int          pos [3];
    int          past [3]; // 0 inside, 1 end flag low, 2 ran off with flag cleared
    int          step_sz;
    logic [5:0]  lvl;
    logic [31:0] rd;

    rsc_scan_if rsc_scan_if_inst ();
    rsc_scan_ctrl rsc_scan_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .scan(rsc_scan_if_inst));
    rsc_sensor_scan rsc_sensor_scan_inst (.hclk(hclk), .hresetn(hresetn),
        .scan(rsc_scan_if_inst), .right_row(right_row), .left_row(left_row),
        .column(column), .addressed_row(addressed_row), .addressed_left(addressed_left),
        .row_selected(row_selected), .row_resetting(row_resetting),
        .column_holding(column_holding), .column_calibrating(column_calibrating),
        .subsample_mode(subsample_mode));
    rsc_scan_sva rsc_scan_sva_inst (.hclk(hclk), .hresetn(hresetn),
        .right_row_sync_n(rsc_scan_if_inst.right_row_sync_n),
        .right_row_step_clock(rsc_scan_if_inst.right_row_step_clock),
        .right_row_end_n(rsc_scan_if_inst.right_row_end_n),
        .column_sync_n(rsc_scan_if_inst.column_sync_n),
        .column_step_clock(rsc_scan_if_inst.column_step_clock),
        .column_end_n(rsc_scan_if_inst.column_end_n),
        .left_row_sync_n(rsc_scan_if_inst.left_row_sync_n),
        .left_row_step_clock(rsc_scan_if_inst.left_row_step_clock),
        .left_row_end_n(rsc_scan_if_inst.left_row_end_n));

    always #25 hclk = ~hclk;

    task automatic test_done();
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                check("hreadyout", {31'h0, hreadyout}, 32'h1);
                test_done();
            end
            @(posedge hclk);
        end
    endtask

    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        if (wr) hwdata <= wd;
        wait_ready();
        q = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    function automatic int lastp(input int a);
        int n;
        if (step_sz == 1) n = (a == 1) ? `RSC_ARRAY_COLS : `RSC_ARRAY_ROWS;
        else n = (a == 1) ? `RSC_SUB_COLS : `RSC_SUB_ROWS;
        return (n - 1) * step_sz;
    endfunction

    // issue a command, wait for busy to drop, then advance the model
    task automatic cmd(input logic [5:0] bits);
        int n;
        bus(1'b1, `RSC_OFS_CMD, {26'h0, bits}, rd);
        n = 0;
        rd = 32'h1;
        while (rd[0] === 1'b1 && n < 20) begin
            bus(1'b0, `RSC_OFS_STATUS, 32'h0, rd);
            n++;
        end
        check("status busy", {31'h0, rd[0]}, 32'h0);
        if (n >= 20) test_done();
        for (int a = 0; a < 3; a++) begin
            if (bits[2*a]) begin
                pos[a] = 0;
                past[a] = 0;
            end else if (bits[2*a+1]) begin
                if (past[a] != 0) past[a] = 2;
                else if (pos[a] == lastp(a)) past[a] = 1;
                else pos[a] += step_sz;
            end
        end
    endtask

    task automatic compare();
        check("right_row", {21'h0, right_row}, pos[0]);
        check("column", {21'h0, column}, pos[1]);
        check("left_row", {21'h0, left_row}, pos[2]);
        check("right_end_n", {31'h0, rsc_scan_if_inst.right_row_end_n}, past[0] != 1);
        check("column_end_n", {31'h0, rsc_scan_if_inst.column_end_n}, past[1] != 1);
        check("left_end_n", {31'h0, rsc_scan_if_inst.left_row_end_n}, past[2] != 1);
        check("addressed_row", {21'h0, addressed_row}, lvl[2] ? pos[2] : pos[0]);
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_count = 0;
        check_count = 0;
        pos = '{0, 0, 0};
        past = '{0, 0, 0};
        step_sz = 1;
        lvl = 6'h00;
        void'($urandom(8516));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `RSC_OFS_LEVEL, 32'h0, rd);
        check("level reset", rd, 32'h0);
        bus(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
        bus(1'b0, 8'h0C, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        bus(1'b0, `RSC_OFS_CMD, 32'h0, rd);
        check("cmd read", rd, 32'h0);
        cmd(6'h15);
        compare();
        for (int i = 0; i < 8; i++) begin
            lvl = (i == 0) ? 6'h3F : 6'($urandom);
            bus(1'b1, `RSC_OFS_LEVEL, {26'h0, lvl}, rd);
            bus(1'b0, `RSC_OFS_LEVEL, 32'h0, rd);
            check("level", rd, {26'h0, lvl});
            repeat (6) @(posedge hclk);
            check("row_selected", {31'h0, row_selected}, lvl[0]);
            check("row_resetting", {31'h0, row_resetting}, lvl[1]);
            check("addressed_left", {31'h0, addressed_left}, lvl[2]);
            check("column_holding", {31'h0, column_holding}, lvl[3]);
            check("column_calibrating", {31'h0, column_calibrating}, lvl[4]);
            check("subsample_mode", {31'h0, subsample_mode}, lvl[5]);
        end
        lvl = 6'h01;
        bus(1'b1, `RSC_OFS_LEVEL, {26'h0, lvl}, rd);
        // the second step lands while busy and must be dropped
        bus(1'b1, `RSC_OFS_CMD, 32'h2, rd);
        cmd(6'h02);
        compare();
        cmd(6'h00);
        compare();
        repeat ($urandom % 9 + 1) cmd(6'h20);
        compare();
        for (int i = 0; i < 1290; i++) begin
            cmd(6'h2A);
            compare();
        end
        bus(1'b0, `RSC_OFS_STATUS, 32'h0, rd);
        check("sticky ends", rd & 32'hE, 32'hE);
        cmd(6'h15);
        bus(1'b1, `RSC_OFS_STATUS, 32'hE, rd);
        bus(1'b0, `RSC_OFS_STATUS, 32'h0, rd);
        check("sticky cleared", rd & 32'hE, 32'h0);
        lvl = 6'h25;
        bus(1'b1, `RSC_OFS_LEVEL, {26'h0, lvl}, rd);
        repeat (6) @(posedge hclk);
        step_sz = 4;
        cmd(6'h15);
        compare();
        for (int i = 0; i < 320; i++) begin
            cmd(6'h2A);
            compare();
        end
        // the column end flag is still low here, so this sync must clear it
        cmd(6'h15);
        compare();
        // reset in mid-run must bring everything back to its first state
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        pos = '{0, 0, 0};
        past = '{0, 0, 0};
        lvl = 6'h00;
        step_sz = 1;
        compare();
        bus(1'b0, `RSC_OFS_LEVEL, 32'h0, rd);
        check("level after reset", rd, 32'h0);
        test_done();
    end
endmodule
